// >>> hw/pwm_consts.svh
// Purpose: constants of the four channel bridge pwm
// Assumes: included by bare name
// Notes:   offsets are byte addresses on the register bus
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PWM_REF_PERIOD_NS   5'h08
`define PWM_UNIT_PERIOD_NS  5'h0A
// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PWM_NCH     4
`define PWM_CNT_W   12
`define PWM_DT_W    8
`define PWM_PL_W    8
`define PWM_ADDR_W  8
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CFG     8'h00
`define OFS_DEAD    8'h04
`define OFS_PLEN    8'h08
`define OFS_TPOS    8'h0C
`define OFS_MODE    8'h10
`define OFS_STAT    8'h14
`define OFS_CH_HI   4'h2
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_ALIGN_LSB  12
`define CFG_HS_INV     14
`define CFG_LS_INV     15
`define CFG_TRG_INV    16
`define DEAD_H_LSB     8
`define TPOS_B_LSB     16
`define CH_SHIFT_LSB   16
`define MODE_W         3
// ----------------------------------------------------------------
// chopper codes, reset values, responses
// ----------------------------------------------------------------
`define CHOP_LS_ON   3'h1
`define CHOP_HS_ON   3'h2
`define CHOP_LS_PWM  3'h5
`define CHOP_HS_PWM  3'h6
`define CHOP_COMP    3'h7
`define STATE_RST    '0
`define DT_START     8'h01
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// >>> hw/pwm_pkg.sv
// Purpose: types of the four channel bridge pwm
// Assumes: pwm_consts.svh
// Notes:   whole block state is one packed struct
`include "pwm_consts.svh"
package pwm_pkg;
   typedef enum logic [1:0] {ALIGN_LEFT, ALIGN_CENTER, ALIGN_RIGHT} align_e;
   typedef logic [`PWM_CNT_W-1:0] cnt_t;
   typedef struct packed {
      logic [3:0]                            div_acc;
      cnt_t                                  cnt;
      cnt_t                                  max_reg;
      cnt_t                                  max_act;
      align_e                                align;
      logic                                  hs_inv;
      logic                                  ls_inv;
      logic                                  trg_inv;
      logic [`PWM_DT_W-1:0]                  dead_l;
      logic [`PWM_DT_W-1:0]                  dead_h;
      logic [`PWM_PL_W-1:0]                  plen;
      cnt_t                                  pos_a;
      cnt_t                                  pos_b;
      logic [`PWM_NCH-1:0][`MODE_W-1:0]      mode;
      logic [`PWM_NCH-1:0][`PWM_CNT_W-1:0]   duty_reg;
      logic [`PWM_NCH-1:0][`PWM_CNT_W-1:0]   duty_act;
      logic [`PWM_NCH-1:0][`PWM_CNT_W-1:0]   shift_reg;
      logic [`PWM_NCH-1:0][`PWM_CNT_W-1:0]   shift_act;
      logic [`PWM_NCH-1:0]                   hs;
      logic [`PWM_NCH-1:0]                   ls;
      logic [`PWM_NCH-1:0][`PWM_DT_W-1:0]    dt;
      logic [3:0][`PWM_PL_W-1:0]             pc;
      logic [`PWM_NCH-1:0]                   out_hs;
      logic [`PWM_NCH-1:0]                   out_ls;
      logic [4:0]                            out_trg;
      logic                                  aw_ok;
      logic                                  w_ok;
      logic [`PWM_ADDR_W-1:0]                aw_addr;
      logic [31:0]                           wdata;
      logic [3:0]                            wstrb;
      logic                                  awready;
      logic                                  wready;
      logic                                  bvalid;
      logic [1:0]                            bresp;
      logic                                  arready;
      logic                                  rvalid;
      logic [31:0]                           rdata;
      logic [1:0]                            rresp;
   } state_s;
endpackage : pwm_pkg

// >>> hw/four_channel_bridge_pwm.sv
// Purpose: four channel half bridge pwm with dead time and triggers
// Assumes: AXI4-Lite register slave, one clock ref_clk
// Notes:   unit tick is 4 of 5 ref_clk cycles, 100 MHz on average
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "pwm_consts.svh"
module four_channel_bridge_pwm (
   input  wire logic                   ref_clk,
   input  wire logic                   arst_n,
   input  wire logic [`PWM_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [`PWM_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   output logic [`PWM_NCH-1:0]         high_side_drive,
   output logic [`PWM_NCH-1:0]         low_side_drive,
   output logic                        cycle_start_trigger,
   output logic                        cycle_center_trigger,
   output logic                        placed_trigger_a,
   output logic                        placed_trigger_b,
   output logic                        placed_trigger_merged
);
   pwm_pkg::state_s        st;
   pwm_pkg::state_s        next_st;
   logic [4:0]             acc_sum;
   logic                   tick;
   logic [12:0]            per;
   logic [`PWM_NCH-1:0]    pwm;
   logic [`PWM_NCH-1:0]    hs_req;
   logic [`PWM_NCH-1:0]    ls_req;

   // ----------------------------------------------------------------
   // register read view and byte merge
   // ----------------------------------------------------------------
   function automatic logic [31:0] rd_word(input pwm_pkg::state_s s,
                                           input logic [7:0] a);
      logic [31:0] w;
      w = '0;
      if (a == `OFS_CFG) begin
         w[`PWM_CNT_W-1:0] = s.max_reg;
         w[`CFG_ALIGN_LSB+:2] = s.align;
         w[`CFG_HS_INV] = s.hs_inv;
         w[`CFG_LS_INV] = s.ls_inv;
         w[`CFG_TRG_INV] = s.trg_inv;
      end else if (a == `OFS_DEAD) begin
         w[`PWM_DT_W-1:0] = s.dead_l;
         w[`DEAD_H_LSB+:`PWM_DT_W] = s.dead_h;
      end else if (a == `OFS_PLEN) begin
         w[`PWM_PL_W-1:0] = s.plen;
      end else if (a == `OFS_TPOS) begin
         w[`PWM_CNT_W-1:0] = s.pos_a;
         w[`TPOS_B_LSB+:`PWM_CNT_W] = s.pos_b;
      end else if (a == `OFS_MODE) begin
         w[`PWM_NCH*`MODE_W-1:0] = s.mode;
      end else if (a == `OFS_STAT) begin
         w[`PWM_CNT_W-1:0] = s.cnt;
         w[`CH_SHIFT_LSB+:`PWM_NCH] = s.hs;
         w[`CH_SHIFT_LSB+8+:`PWM_NCH] = s.ls;
      end else if (a[7:4] == `OFS_CH_HI) begin
         w[`PWM_CNT_W-1:0] = s.duty_reg[a[3:2]];
         w[`CH_SHIFT_LSB+:`PWM_CNT_W] = s.shift_reg[a[3:2]];
      end
      return w;
   endfunction : rd_word

   function automatic logic mapped(input logic [7:0] a);
      return (a <= `OFS_STAT) || (a[7:4] == `OFS_CH_HI);
   endfunction : mapped

   // ----------------------------------------------------------------
   // unit tick and per channel compare
   // ----------------------------------------------------------------
   assign acc_sum = {1'b0, st.div_acc} + `PWM_REF_PERIOD_NS;
   assign tick = acc_sum >= `PWM_UNIT_PERIOD_NS;
   assign per = {1'b0, st.max_act} + 13'h0001;

   genvar g;
   for (g = 0; g < `PWM_NCH; g++) begin : g_ch
      logic [12:0] d;
      logic [12:0] sh;
      logic [12:0] cs;
      logic [12:0] lo;
      always_comb begin
         d = ({1'b0, st.duty_act[g]} > per) ? per : {1'b0, st.duty_act[g]};
         sh = {1'b0, st.shift_act[g]};
         // shifted counter, wraps inside the period
         if ({1'b0, st.cnt} >= sh) begin
            cs = 13'({1'b0, st.cnt} - sh);
         end else begin
            cs = 13'({1'b0, st.cnt} + per - sh);
         end
         case (st.align)
            pwm_pkg::ALIGN_CENTER: lo = 13'((per - d) >> 1);
            pwm_pkg::ALIGN_RIGHT:  lo = 13'(per - d);
            default:               lo = '0;
         endcase
         pwm[g] = (cs >= lo) && (cs < 13'(lo + d));
         hs_req[g] = 1'b0;
         ls_req[g] = 1'b0;
         case (st.mode[g])
            `CHOP_LS_ON:  ls_req[g] = 1'b1;
            `CHOP_HS_ON:  hs_req[g] = 1'b1;
            `CHOP_LS_PWM: ls_req[g] = pwm[g];
            `CHOP_HS_PWM: hs_req[g] = pwm[g];
            `CHOP_COMP: begin
               hs_req[g] = pwm[g];
               ls_req[g] = !pwm[g];
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] wv;
      logic [12:0] pn;
      logic [3:0]  evt;
      wv = '0;
      pn = '0;
      evt = '0;
      next_st = st;
      next_st.div_acc = tick ? 4'(acc_sum - `PWM_UNIT_PERIOD_NS) : acc_sum[3:0];
      if (tick) begin
         if (st.cnt == st.max_act) begin
            next_st.cnt = '0;
            next_st.max_act = st.max_reg;
            next_st.duty_act = st.duty_reg;
            next_st.shift_act = st.shift_reg;
         end else begin
            next_st.cnt = 12'(st.cnt + 12'h001);
         end
         pn = {1'b0, next_st.max_act} + 13'h0001;
         evt[0] = next_st.cnt == '0;
         evt[1] = next_st.cnt == 12'(pn >> 1);
         evt[2] = next_st.cnt == st.pos_a;
         evt[3] = next_st.cnt == st.pos_b;
         for (int j = 0; j < 4; j++) begin
            if (evt[j]) begin
               next_st.pc[j] = st.plen;
            end else if (st.pc[j] != '0) begin
               next_st.pc[j] = 8'(st.pc[j] - 8'h01);
            end
         end
         for (int i = 0; i < `PWM_NCH; i++) begin
            if (st.hs[i] && !hs_req[i]) begin
               next_st.hs[i] = 1'b0;
               next_st.dt[i] = `DT_START;
            end else if (st.ls[i] && !ls_req[i]) begin
               next_st.ls[i] = 1'b0;
               next_st.dt[i] = `DT_START;
            end else if (!st.hs[i] && !st.ls[i]) begin
               if (hs_req[i] && st.dt[i] >= st.dead_h) begin
                  next_st.hs[i] = 1'b1;
               end else if (ls_req[i] && st.dt[i] >= st.dead_l) begin
                  next_st.ls[i] = 1'b1;
               end else if (st.dt[i] != '1) begin
                  next_st.dt[i] = 8'(st.dt[i] + 8'h01);
               end
            end
         end
      end
      next_st.out_hs = next_st.hs ^ {`PWM_NCH{st.hs_inv}};
      next_st.out_ls = next_st.ls ^ {`PWM_NCH{st.ls_inv}};
      for (int j = 0; j < 4; j++) begin
         next_st.out_trg[j] = (next_st.pc[j] != '0) ^ st.trg_inv;
      end
      next_st.out_trg[4] = ((next_st.pc[2] != '0) || (next_st.pc[3] != '0)) ^ st.trg_inv;
      // bus write side
      if (awvalid && st.awready) begin
         next_st.aw_ok = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && st.wready) begin
         next_st.w_ok = 1'b1;
         next_st.wdata = wdata;
         next_st.wstrb = wstrb;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.aw_ok && st.w_ok && !st.bvalid) begin
         wv = rd_word(st, st.aw_addr);
         for (int b = 0; b < 4; b++) begin
            if (st.wstrb[b]) begin
               wv[b*8+:8] = st.wdata[b*8+:8];
            end
         end
         next_st.aw_ok = 1'b0;
         next_st.w_ok = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = mapped(st.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         if (st.aw_addr == `OFS_CFG) begin
            next_st.max_reg = wv[`PWM_CNT_W-1:0];
            next_st.align = (wv[`CFG_ALIGN_LSB+:2] == 2'h3) ? pwm_pkg::ALIGN_LEFT
                          : pwm_pkg::align_e'(wv[`CFG_ALIGN_LSB+:2]);
            next_st.hs_inv = wv[`CFG_HS_INV];
            next_st.ls_inv = wv[`CFG_LS_INV];
            next_st.trg_inv = wv[`CFG_TRG_INV];
         end else if (st.aw_addr == `OFS_DEAD) begin
            next_st.dead_l = wv[`PWM_DT_W-1:0];
            next_st.dead_h = wv[`DEAD_H_LSB+:`PWM_DT_W];
         end else if (st.aw_addr == `OFS_PLEN) begin
            next_st.plen = wv[`PWM_PL_W-1:0];
         end else if (st.aw_addr == `OFS_TPOS) begin
            next_st.pos_a = wv[`PWM_CNT_W-1:0];
            next_st.pos_b = wv[`TPOS_B_LSB+:`PWM_CNT_W];
         end else if (st.aw_addr == `OFS_MODE) begin
            next_st.mode = wv[`PWM_NCH*`MODE_W-1:0];
         end else if (st.aw_addr[7:4] == `OFS_CH_HI) begin
            next_st.duty_reg[st.aw_addr[3:2]] = wv[`PWM_CNT_W-1:0];
            next_st.shift_reg[st.aw_addr[3:2]] = wv[`CH_SHIFT_LSB+:`PWM_CNT_W];
         end
      end
      next_st.awready = !next_st.aw_ok && !next_st.bvalid;
      next_st.wready = !next_st.w_ok && !next_st.bvalid;
      // bus read side
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_word(st, araddr);
         next_st.rresp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      next_st.arready = !next_st.rvalid;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= `STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign awready = st.awready;
   assign wready = st.wready;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign arready = st.arready;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign high_side_drive = st.out_hs;
   assign low_side_drive = st.out_ls;
   assign cycle_start_trigger = st.out_trg[0];
   assign cycle_center_trigger = st.out_trg[1];
   assign placed_trigger_a = st.out_trg[2];
   assign placed_trigger_b = st.out_trg[3];
   assign placed_trigger_merged = st.out_trg[4];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_wrap;
      tick && (st.cnt == st.max_act);
   endsequence
   sequence s_step;
      tick && (st.cnt != st.max_act);
   endsequence
   sequence s_pos_a;
      tick && (next_st.cnt == st.pos_a);
   endsequence
   sequence s_pos_b;
      tick && (next_st.cnt == st.pos_b);
   endsequence

   a_cnt_wrap: assert property (s_wrap |=> st.cnt == '0)
      else $error("counter did not wrap at limit");
   a_cnt_step: assert property (s_step |=> st.cnt == 12'($past(st.cnt) + 12'h001))
      else $error("counter did not step by one");
   a_shadow_load: assert property (s_wrap |=> st.max_act == $past(st.max_reg))
      else $error("limit not loaded at cycle start");
   a_side_excl: assert property (!(st.hs[0] && st.ls[0]))
      else $error("both sides on in channel 0");
   a_low_dead: assert property ($rose(st.ls[0]) |->
      $past(st.dt[0]) >= $past(st.dead_l))
      else $error("low side on before dead time");
   a_high_dead: assert property ($rose(st.hs[0]) |->
      $past(st.dt[0]) >= $past(st.dead_h))
      else $error("high side on before dead time");
   a_low_chop_only: assert property ((st.mode[0] == 3'h5)[*3] |-> !st.hs[0])
      else $error("mode 101 left high side on");
   a_high_chop_only: assert property ((st.mode[0] == 3'h6)[*3] |-> !st.ls[0])
      else $error("mode 110 left low side on");
   a_high_polarity: assert property (##1 high_side_drive ==
      (st.hs ^ {`PWM_NCH{$past(st.hs_inv)}}))
      else $error("high side polarity wrong");
   a_low_polarity: assert property (##1 low_side_drive ==
      (st.ls ^ {`PWM_NCH{$past(st.ls_inv)}}))
      else $error("low side polarity wrong");
   a_pos_a_load: assert property (s_pos_a |=> st.pc[2] == $past(st.plen))
      else $error("pulse a length not loaded");
   a_pos_b_load: assert property (s_pos_b |=> st.pc[3] == $past(st.plen))
      else $error("pulse b length not loaded");
   a_pulse_hold: assert property (!tick |=> st.pc == $past(st.pc))
      else $error("pulse count moved without tick");
   a_mode_off: assert property ((st.mode[0] == 3'h0)[*3] |-> !st.hs[0] && !st.ls[0])
      else $error("mode 000 left a side on");
   a_merged_or: assert property (##1 placed_trigger_merged ==
      ($past(st.trg_inv) ^ ((st.pc[2] != '0) || (st.pc[3] != '0))))
      else $error("merged trigger is not the or");
   a_zero_pulse: assert property (tick && next_st.cnt == '0 |=> st.pc[0] == $past(st.plen))
      else $error("start pulse length not loaded");
endmodule : four_channel_bridge_pwm

// >>> bench/drive_monitor.sv
// Purpose: far side model, gate drivers and trigger inputs
// Assumes: positive logic on all lines
// Notes:   run lengths and offsets counted in ref_clk cycles
`timescale 1ns/1ps
module drive_monitor (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  hs,
   input  wire logic [3:0]  ls,
   input  wire logic        start,
   input  wire logic        center,
   input  wire logic        trg_a,
   input  wire logic        trg_b,
   output logic [15:0]      period,
   output logic [15:0]      start_w,
   output logic [15:0]      ofs_c,
   output logic [15:0]      ofs_a,
   output logic [15:0]      ofs_b,
   output logic [3:0][15:0] hs_len,
   output logic [3:0][15:0] ls_len,
   output logic [3:0][15:0] hs_ofs,
   output logic [3:0][15:0] gap_l,
   output logic [3:0][15:0] gap_h,
   output logic             overlap
);
   logic [3:0]       hp, lp;
   logic             sp, cp, ap, bp;
   logic [15:0]      since, cur, sw;
   logic [3:0][15:0] hc, lc, oc;
   // ----------------------------------------
   // measurement
   // ----------------------------------------
   assign cur = (start && !sp) ? 16'h0000 : since + 16'h0001;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         {hp, lp, sp, cp, ap, bp, overlap, since, sw, hc, lc, oc} <= '0;
      end else begin
         {hp, lp, sp, cp, ap, bp} <= {hs, ls, start, center, trg_a, trg_b};
         since <= cur;
         sw <= start ? sw + 16'h0001 : 16'h0000;
         if (start && !sp) period <= since + 16'h0001;
         if (!start && sp) start_w <= sw;
         if (center && !cp) ofs_c <= cur;
         if (trg_a && !ap) ofs_a <= cur;
         if (trg_b && !bp) ofs_b <= cur;
         for (int i = 0; i < 4; i++) begin
            hc[i] <= hs[i] ? hc[i] + 16'h0001 : 16'h0000;
            lc[i] <= ls[i] ? lc[i] + 16'h0001 : 16'h0000;
            oc[i] <= (hs[i] || ls[i]) ? 16'h0000 : oc[i] + 16'h0001;
            if (!hs[i] && hp[i]) hs_len[i] <= hc[i];
            if (!ls[i] && lp[i]) ls_len[i] <= lc[i];
            if (hs[i] && !hp[i]) hs_ofs[i] <= cur;
            if (hs[i] && !hp[i]) gap_h[i] <= oc[i];
            if (ls[i] && !lp[i]) gap_l[i] <= oc[i];
            if (hs[i] && ls[i]) overlap <= 1'b1;
         end
      end
   end
endmodule : drive_monitor

// >>> bench/four_channel_bridge_pwm_tb.sv
// Purpose: self checking bench of the four channel bridge pwm
// Assumes: 4 unit ticks span exactly 5 ref_clk cycles
// Notes:   limit 39, so one period is 50 ref_clk cycles
`timescale 1ns/1ps
`include "pwm_consts.svh"
module four_channel_bridge_pwm_tb;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0]  r;
   } row_s;
   logic             ref_clk, arst_n, awvalid, wvalid, bready, arvalid, rready, inv;
   logic             awready, wready, bvalid, arready, rvalid, t_s, t_c, t_a, t_b, t_m;
   logic [7:0]       awaddr, araddr, ns;
   logic [31:0]      wdata, rdata, d;
   logic [3:0]       wstrb, hsd, lsd;
   logic [1:0]       bresp, rresp, r;
   logic [15:0]      per, sw, oc, oa, ob, o0, l0;
   logic [3:0][15:0] hl, ll, ho, gl, gh;
   logic             ovl;
   logic [7:0]       nh [4];
   logic [7:0]       nl [4];
   int               n_errors, n_checks;
   row_s rows [10] = '{
      '{8'h00, 32'h00000027, 32'h00000027, 2'h0}, '{8'h04, 32'h00000804, 32'h00000804, 2'h0},
      '{8'h08, 32'h00000004, 32'h00000004, 2'h0}, '{8'h0C, 32'h00180008, 32'h00180008, 2'h0},
      '{8'h10, 32'h00000FFF, 32'h00000FFF, 2'h0}, '{8'h20, 32'h00000014, 32'h00000014, 2'h0},
      '{8'h24, 32'h00000014, 32'h00000014, 2'h0}, '{8'h28, 32'h00000014, 32'h00000014, 2'h0},
      '{8'h2C, 32'h00000014, 32'h00000014, 2'h0}, '{8'h30, 32'h00000055, 32'h00000000, 2'h2}};
   logic [1:0]  hx [8] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
   logic [1:0]  lx [8] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1};
   logic [31:0] acfg [3] = '{32'h00001027, 32'h00002027, 32'h00000027};
   logic [31:0] ach0 [3] = '{32'h00000010, 32'h00000010, 32'h00080010};
   logic [15:0] adif [3] = '{16'h000F, 16'h001E, 16'h000A};

   four_channel_bridge_pwm four_channel_bridge_pwm_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .high_side_drive(hsd), .low_side_drive(lsd),
      .cycle_start_trigger(t_s), .cycle_center_trigger(t_c), .placed_trigger_a(t_a),
      .placed_trigger_b(t_b), .placed_trigger_merged(t_m));
   drive_monitor drive_monitor_i (.ref_clk(ref_clk), .arst_n(arst_n), .hs(hsd), .ls(lsd),
      .start(t_s), .center(t_c), .trg_a(t_a), .trg_b(t_b), .period(per), .start_w(sw),
      .ofs_c(oc), .ofs_a(oa), .ofs_b(ob), .hs_len(hl), .ls_len(ll), .hs_ofs(ho),
      .gap_l(gl), .gap_h(gh), .overlap(ovl));

   always #4 ref_clk = ~ref_clk;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tmo();
      n_errors++;
      $display("MISMATCH wait expected answer seen none");
      summarize();
   endtask : tmo
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge ref_clk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, 4'hF, 3'b111};
      do begin
         @(posedge ref_clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      rs = bresp;
      bready <= 1'b0;
      if (n >= 100) tmo();
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge ref_clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do begin
         @(posedge ref_clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n >= 100) tmo();
   endtask : axi_read
   task automatic wait_start(input int k);
      int   n;
      logic p, hit;
      repeat (k) begin
         n = 0;
         p = 1'b1;
         do begin
            @(posedge ref_clk);
            n++;
            hit = (t_s === 1'b1) && !p;
            p = (t_s === 1'b1);
         end while (!hit && n < 200);
         if (n >= 200) tmo();
      end
   endtask : wait_start
   task automatic cnt_period();
      ns = 8'h00;
      for (int i = 0; i < 4; i++) begin
         nh[i] = 8'h00;
         nl[i] = 8'h00;
      end
      repeat (50) begin
         @(posedge ref_clk);
         ns = ns + {7'h00, t_s};
         for (int i = 0; i < 4; i++) begin
            nh[i] = nh[i] + {7'h00, hsd[i]};
            nl[i] = nl[i] + {7'h00, lsd[i]};
         end
      end
   endtask : cnt_period
   function automatic logic [1:0] cls(input logic [7:0] n);
      cls = (n == 8'h00) ? 2'h0 : ((n == 8'h32) ? 2'h2 : 2'h1);
   endfunction : cls
   // ----------------------------------------
   // merged trigger watch and main sequence
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (arst_n && !inv && t_m !== (t_a | t_b)) begin
         n_errors++;
         $display("MISMATCH merged expected %b seen %b", t_a | t_b, t_m);
      end
   end
   initial begin
      #720000 tmo();
   end
   initial begin
      {ref_clk, arst_n, awvalid, wvalid, bready, arvalid, rready, inv} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      n_errors = 0;
      n_checks = 0;
      repeat (16) @(posedge ref_clk);
      chk("drive_rst", 32'h0, {24'h0, hsd, lsd});
      chk("trg_rst", 32'h0, {27'h0, t_s, t_c, t_a, t_b, t_m});
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < 10; i++) begin
         axi_write(rows[i].a, rows[i].d, r);
         chk("bresp", {30'h0, rows[i].r}, {30'h0, r});
         axi_read(rows[i].a, d, r);
         chk("rresp", {30'h0, rows[i].r}, {30'h0, r});
         chk("rdata", rows[i].e, d);
      end
      wait_start(3);
      chk("period", 32'd50, 32'(per));
      chk("pulse_w", 32'd5, 32'(sw));
      chk("ofs_c", 32'd25, 32'(oc));
      chk("ofs_a", 32'd10, 32'(oa));
      chk("ofs_b", 32'd30, 32'(ob));
      for (int i = 0; i < 4; i++) begin
         chk("hs_len", 32'd15, 32'(hl[i]));
         chk("ls_len", 32'd20, 32'(ll[i]));
         chk("gap_l", 32'd5, 32'(gl[i]));
         chk("gap_h", 32'd10, 32'(gh[i]));
      end
      for (int c = 0; c < 8; c++) begin
         axi_write(8'h10, {26'h0, 3'(7 - c), 3'(c)}, r);
         wait_start(2);
         cnt_period();
         chk("hs_ch0", {30'h0, hx[c]}, {30'h0, cls(nh[0])});
         chk("ls_ch0", {30'h0, lx[c]}, {30'h0, cls(nl[0])});
         chk("hs_ch1", {30'h0, hx[7 - c]}, {30'h0, cls(nh[1])});
         chk("ls_ch1", {30'h0, lx[7 - c]}, {30'h0, cls(nl[1])});
      end
      axi_write(8'h10, 32'h00000036, r);
      axi_write(8'h20, 32'h00000010, r);
      axi_write(8'h24, 32'h00000020, r);
      wait_start(3);
      o0 = ho[0];
      l0 = hl[0];
      chk("duty_diff", 32'd20, 32'(hl[1] - hl[0]));
      for (int i = 0; i < 3; i++) begin
         axi_write(8'h00, acfg[i], r);
         axi_write(8'h20, ach0[i], r);
         wait_start(3);
         chk("align_ofs", 32'(adif[i]), 32'(ho[0] - o0));
         chk("align_len", 32'(l0), 32'(hl[0]));
      end
      chk("overlap", 32'h0, {31'h0, ovl});
      axi_write(8'h10, 32'h00000000, r);
      inv <= 1'b1;
      axi_write(8'h00, 32'h0001C027, r);
      repeat (3) @(posedge ref_clk);
      chk("inv_drive", 32'h000000FF, {24'h0, hsd, lsd});
      cnt_period();
      chk("inv_start", 32'd45, {24'h0, ns});
      summarize();
   end
endmodule : four_channel_bridge_pwm_tb
